// *** rtl/probe_status_pkg.sv ***
// Purpose: Shared constants of the probe status register bank.
// Assumes: Register addresses are the zero-based word addresses seen on the line.
// Notes: 32-bit values occupy two words, less significant word at the lower address.
`default_nettype none

package probe_status_pkg;

  // ---------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------
  localparam logic [15:0] ADDR_OVERALL = 16'h0200;
  localparam logic [15:0] ADDR_FAULT_LOW = 16'h0201;
  localparam logic [15:0] ADDR_FAULT_HIGH = 16'h0203;
  localparam logic [15:0] ADDR_PEROXIDE_COND = 16'h0210;
  localparam logic [15:0] ADDR_DEW_POINT_COND = 16'h0215;
  localparam logic [15:0] ADDR_WATER_COND = 16'h0217;
  localparam logic [15:0] ADDR_SENSOR_LIFE = 16'h0222;
  localparam logic [15:0] ADDR_TEST_SIGNED = 16'h1f00;
  localparam logic [15:0] ADDR_TEST_FLOAT = 16'h1f01;
  localparam logic [15:0] ADDR_TEST_TEXT = 16'h1f03;
  localparam int TEST_TEXT_WORDS = 4;

  // ---------------------------------------------------------------
  // Overall condition weights (bit positions)
  // ---------------------------------------------------------------
  localparam int COND_CRITICAL = 0;
  localparam int COND_ERROR = 1;
  localparam int COND_WARNING = 2;
  localparam int COND_NOTICE = 3;
  localparam int COND_CAL_MODE = 4;

  // ---------------------------------------------------------------
  // Per-measurement condition weights (bit positions)
  // ---------------------------------------------------------------
  localparam int MEAS_UNRELIABLE = 1;
  localparam int MEAS_FROZEN = 5;
  localparam int MEAS_CAL_EXPIRED = 6;
  localparam int MEAS_SENSOR_FAIL = 7;
  localparam int MEAS_NOT_READY = 8;
  localparam int MEAS_COUNT = 3;
  localparam int MEAS_FLAGS = 5;

  // ---------------------------------------------------------------
  // Fault code classes
  // ---------------------------------------------------------------
  localparam logic [31:0] LOW_CRITICAL_MASK = 32'h0000_0003;
  localparam logic [31:0] LOW_ERROR_MASK = 32'h000c_c478;
  localparam logic [31:0] HIGH_ERROR_MASK = 32'h0000_5300;
  localparam logic [31:0] HIGH_INFO_MASK = 32'h0000_a000;
  localparam logic [31:0] HIGH_WARNING_MASK = 32'h0001_0000;
  localparam int HIGH_PURGE_BIT = 13;
  localparam int HIGH_CAL_EXPIRED_BIT = 16;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] OVERALL_RESET = 16'h0000;
  localparam logic [31:0] FAULT_RESET = 32'h0000_0000;
  localparam logic [15:0] MEAS_RESET = 16'h0100;
  localparam logic [31:0] LIFE_RESET = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Test constants
  // ---------------------------------------------------------------
  localparam logic [15:0] TEST_SIGNED_VALUE = 16'hcfc7;
  localparam logic [31:0] TEST_FLOAT_VALUE = 32'hc2f6_e666;
  localparam logic [63:0] TEST_TEXT_VALUE = 64'h2d31_3233_2e34_3500;

  // ---------------------------------------------------------------
  // Exceptions and identification objects
  // ---------------------------------------------------------------
  localparam logic [7:0] EXC_READ_ONLY = 8'h01;
  localparam logic [7:0] EXC_BAD_ADDRESS = 8'h02;
  localparam logic [7:0] OBJ_VERSION = 8'h02;
  localparam logic [7:0] OBJ_SERIAL = 8'h80;
  localparam logic [7:0] OBJ_CAL_DATE = 8'h81;
  localparam logic [7:0] OBJ_CAL_INFO = 8'h82;
  localparam int DATE_CHARS = 10;
  localparam int MAX_CHARS = 64;

endpackage : probe_status_pkg

`default_nettype wire

// *** rtl/id_text_picker.sv ***
// Purpose: Picks one character of an identification object text.
// Assumes: Texts are packed with the first character in the top byte, NUL padded.
// Notes: Past the end of a text, or for an invalid text, the character is zero.
`default_nettype none

module id_text_picker #(
  parameter int VER_CHARS = 16,
  parameter int SERIAL_CHARS = 16,
  parameter int INFO_CHARS = 32
) (
  // Selection
  input wire logic [7:0] obj_id,
  input wire logic [5:0] char_index,
  // Texts
  input wire logic [8*VER_CHARS-1:0] version_text,
  input wire logic [8*SERIAL_CHARS-1:0] unit_serial_object,
  input wire logic [8*probe_status_pkg::DATE_CHARS-1:0] cal_date_object,
  input wire logic cal_date_valid,
  input wire logic [8*INFO_CHARS-1:0] cal_info_object,
  input wire logic cal_info_valid,
  // Result
  output logic [7:0] char_out,
  output logic known
);

  localparam int W = 8 * probe_status_pkg::MAX_CHARS;

  function automatic logic [7:0] pick(input logic [W-1:0] t, input logic [5:0] i);
    pick = t[8 * (probe_status_pkg::MAX_CHARS - 1 - int'(i)) +: 8];
  endfunction : pick

  logic [W-1:0] ver_wide;
  logic [W-1:0] serial_wide;
  logic [W-1:0] date_wide;
  logic [W-1:0] info_wide;

  assign ver_wide = {version_text, {(W - 8 * VER_CHARS){1'b0}}};
  assign serial_wide = {unit_serial_object, {(W - 8 * SERIAL_CHARS){1'b0}}};
  assign date_wide = {cal_date_object, {(W - 8 * probe_status_pkg::DATE_CHARS){1'b0}}};
  assign info_wide = {cal_info_object, {(W - 8 * INFO_CHARS){1'b0}}};

  always_comb begin
    char_out = 8'h00;
    known = 1'b1;
    case (obj_id)
      probe_status_pkg::OBJ_VERSION: char_out = pick(ver_wide, char_index);
      probe_status_pkg::OBJ_SERIAL: char_out = pick(serial_wide, char_index);
      probe_status_pkg::OBJ_CAL_DATE: begin
        // Empty string when no valid date is held
        char_out = cal_date_valid ? pick(date_wide, char_index) : 8'h00;
      end
      probe_status_pkg::OBJ_CAL_INFO: begin
        char_out = cal_info_valid ? pick(info_wide, char_index) : 8'h00;
      end
      default: known = 1'b0;
    endcase
  end

endmodule : id_text_picker

`default_nettype wire

// *** rtl/probe_status_bank.sv ***
// Purpose: Read-only status, diagnostic, identification and test register bank.
// Assumes: Condition inputs come from logic on core_clk; framing is done outside.
// Notes: One word request per cycle, answered one cycle later.
//
// Summary of operation
// - Overall condition word: 1 critical, 2 error, 4 warning, 8 notice, 16 calibration.
// - Simultaneous conditions read as the sum of their weights.
// - Measurement word: 2 unreliable, 32 frozen, 64 expired, 128 failed, 256 not ready.
// - Low fault word: 1 checksum, 2 settings corrupt, 8 supply voltage high.
// - Low fault word: 16 internal voltage low, 32 internal voltage high, errors.
// - Low fault word: humidity open 64, 1024; temperature 16384, 32768, 262144, 524288.
// - High fault word: 256 external converter, 512 storage, 4096 humidity short.
// - High fault word: 16384 internal converter failure, an error.
// - High fault word: 8192 purge, 32768 expiry near, 65536 calibration expired.
// - Sensor life is a float percentage, 100 fresh down to 0.
// - Object 129 returns calibration date text, empty when invalid.
// - Object 130 returns calibration info text, empty when invalid.
// - Object 2 returns the software version text.
// - Test constants -12345, float -123.45 and text of the same figure.
// - Measurement condition words cannot be altered by the host.
// - Floats use two words, less significant word first.
`default_nettype none

module probe_status_bank #(
  parameter int VER_CHARS = 16,
  parameter int SERIAL_CHARS = 16,
  parameter int INFO_CHARS = 32
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Register request
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [15:0] req_addr,
  // Register answer
  output logic resp_valid,
  output logic [15:0] resp_data,
  output logic resp_exception,
  output logic [7:0] resp_exc_code,
  // Identification object request
  input wire logic obj_req,
  input wire logic [7:0] obj_id,
  input wire logic [5:0] obj_char_index,
  // Identification object answer
  output logic obj_valid,
  output logic [7:0] obj_char,
  output logic obj_exception,
  // Device conditions
  input wire logic [31:0] fault_low_in,
  input wire logic [31:0] fault_high_in,
  input wire logic [probe_status_pkg::MEAS_COUNT-1:0][probe_status_pkg::MEAS_FLAGS-1:0]
    meas_flags,
  input wire logic cal_mode,
  input wire logic [31:0] sensor_life_in,
  // Identification texts
  input wire logic [8*VER_CHARS-1:0] version_text,
  input wire logic [8*SERIAL_CHARS-1:0] unit_serial_object,
  input wire logic [8*probe_status_pkg::DATE_CHARS-1:0] cal_date_object,
  input wire logic cal_date_valid,
  input wire logic [8*INFO_CHARS-1:0] cal_info_object,
  input wire logic cal_info_valid
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] overall;
    logic [31:0] fault_low;
    logic [31:0] fault_high;
    logic [probe_status_pkg::MEAS_COUNT-1:0][15:0] meas;
    logic [31:0] life;
    logic [15:0] hold_word;
    logic [15:0] hold_addr;
    logic hold_ok;
    logic resp_valid;
    logic [15:0] resp_data;
    logic resp_exception;
    logic [7:0] resp_exc_code;
    logic obj_valid;
    logic [7:0] obj_char;
    logic obj_exception;
  } state_s;

  state_s st;
  state_s next_st;

  // ---------------------------------------------------------------
  // Decoding
  // ---------------------------------------------------------------
  function automatic logic [15:0] meas_word(input logic [probe_status_pkg::MEAS_FLAGS-1:0] f);
    meas_word = 16'h0000;
    meas_word[probe_status_pkg::MEAS_UNRELIABLE] = f[0];
    meas_word[probe_status_pkg::MEAS_FROZEN] = f[1];
    meas_word[probe_status_pkg::MEAS_CAL_EXPIRED] = f[2];
    meas_word[probe_status_pkg::MEAS_SENSOR_FAIL] = f[3];
    meas_word[probe_status_pkg::MEAS_NOT_READY] = f[4];
  endfunction : meas_word

  // Returns {hit, data}; 32-bit values answer low word at base, high word at base+1
  function automatic logic [16:0] read_word(input logic [15:0] a, input state_s s);
    logic [63:0] txt;
    txt = probe_status_pkg::TEST_TEXT_VALUE;
    read_word = {1'b1, 16'h0000};
    case (a)
      probe_status_pkg::ADDR_OVERALL: read_word[15:0] = s.overall;
      probe_status_pkg::ADDR_FAULT_LOW: read_word[15:0] = s.fault_low[15:0];
      probe_status_pkg::ADDR_FAULT_LOW + 16'h0001: read_word[15:0] = s.fault_low[31:16];
      probe_status_pkg::ADDR_FAULT_HIGH: read_word[15:0] = s.fault_high[15:0];
      probe_status_pkg::ADDR_FAULT_HIGH + 16'h0001: read_word[15:0] = s.fault_high[31:16];
      probe_status_pkg::ADDR_PEROXIDE_COND: read_word[15:0] = s.meas[0];
      probe_status_pkg::ADDR_DEW_POINT_COND: read_word[15:0] = s.meas[1];
      probe_status_pkg::ADDR_WATER_COND: read_word[15:0] = s.meas[2];
      probe_status_pkg::ADDR_SENSOR_LIFE: read_word[15:0] = s.life[15:0];
      probe_status_pkg::ADDR_SENSOR_LIFE + 16'h0001: read_word[15:0] = s.life[31:16];
      probe_status_pkg::ADDR_TEST_SIGNED: begin
        read_word[15:0] = probe_status_pkg::TEST_SIGNED_VALUE;
      end
      probe_status_pkg::ADDR_TEST_FLOAT: begin
        read_word[15:0] = probe_status_pkg::TEST_FLOAT_VALUE[15:0];
      end
      probe_status_pkg::ADDR_TEST_FLOAT + 16'h0001: begin
        read_word[15:0] = probe_status_pkg::TEST_FLOAT_VALUE[31:16];
      end
      probe_status_pkg::ADDR_TEST_TEXT: read_word[15:0] = txt[63:48];
      probe_status_pkg::ADDR_TEST_TEXT + 16'h0001: read_word[15:0] = txt[47:32];
      probe_status_pkg::ADDR_TEST_TEXT + 16'h0002: read_word[15:0] = txt[31:16];
      probe_status_pkg::ADDR_TEST_TEXT + 16'h0003: read_word[15:0] = txt[15:0];
      default: read_word = {1'b0, 16'h0000};
    endcase
  endfunction : read_word

  // ---------------------------------------------------------------
  // Identification objects
  // ---------------------------------------------------------------
  logic [7:0] picked_char;
  logic picked_known;

  id_text_picker #(
    .VER_CHARS(VER_CHARS),
    .SERIAL_CHARS(SERIAL_CHARS),
    .INFO_CHARS(INFO_CHARS)
  ) u_picker (
    .obj_id(obj_id),
    .char_index(obj_char_index),
    .version_text(version_text),
    .unit_serial_object(unit_serial_object),
    .cal_date_object(cal_date_object),
    .cal_date_valid(cal_date_valid),
    .cal_info_object(cal_info_object),
    .cal_info_valid(cal_info_valid),
    .char_out(picked_char),
    .known(picked_known)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic [16:0] rd_now;
  logic [16:0] rd_upper;
  logic [15:0] addr_plus;

  always_comb begin
    next_st = st;
    addr_plus = 16'(req_addr + 16'h0001);
    rd_now = read_word(req_addr, st);
    rd_upper = read_word(addr_plus, st);
    // Snapshot of the device conditions; powers of two so OR equals sum
    next_st.fault_low = fault_low_in & (probe_status_pkg::LOW_CRITICAL_MASK |
      probe_status_pkg::LOW_ERROR_MASK);
    next_st.fault_high = fault_high_in & (probe_status_pkg::HIGH_ERROR_MASK |
      probe_status_pkg::HIGH_INFO_MASK |
      probe_status_pkg::HIGH_WARNING_MASK);
    next_st.overall = 16'h0000;
    next_st.overall[probe_status_pkg::COND_CRITICAL] =
      |(fault_low_in & probe_status_pkg::LOW_CRITICAL_MASK);
    next_st.overall[probe_status_pkg::COND_ERROR] =
      |(fault_low_in & probe_status_pkg::LOW_ERROR_MASK) |
      |(fault_high_in & probe_status_pkg::HIGH_ERROR_MASK);
    next_st.overall[probe_status_pkg::COND_WARNING] =
      |(fault_high_in & probe_status_pkg::HIGH_WARNING_MASK);
    next_st.overall[probe_status_pkg::COND_NOTICE] =
      |(fault_high_in & probe_status_pkg::HIGH_INFO_MASK);
    next_st.overall[probe_status_pkg::COND_CAL_MODE] = cal_mode;
    for (int m = 0; m < probe_status_pkg::MEAS_COUNT; m++) begin
      next_st.meas[m] = meas_word(meas_flags[m]);
    end
    next_st.life = sensor_life_in;
    // Answer defaults
    next_st.resp_valid = req_valid;
    next_st.resp_data = 16'h0000;
    next_st.resp_exception = 1'b0;
    next_st.resp_exc_code = 8'h00;
    if (req_valid && req_write) begin
      // Nothing in this bank is writable; contents stay untouched
      next_st.resp_exception = 1'b1;
      next_st.resp_exc_code = rd_now[16] ? probe_status_pkg::EXC_READ_ONLY :
        probe_status_pkg::EXC_BAD_ADDRESS;
    end else if (req_valid && !rd_now[16]) begin
      next_st.resp_exception = 1'b1;
      next_st.resp_exc_code = probe_status_pkg::EXC_BAD_ADDRESS;
    end else if (req_valid) begin
      // Upper half is frozen with the lower read; a pair tears only if its lower half came from the hold or another hit read came between
      if (st.hold_ok && req_addr == st.hold_addr) begin
        next_st.resp_data = st.hold_word;
      end else begin
        next_st.resp_data = rd_now[15:0];
      end
      next_st.hold_ok = rd_upper[16];
      next_st.hold_addr = addr_plus;
      next_st.hold_word = rd_upper[15:0];
    end
    next_st.obj_valid = obj_req;
    next_st.obj_char = (obj_req && picked_known) ? picked_char : 8'h00;
    next_st.obj_exception = obj_req && !picked_known;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
      st.overall <= probe_status_pkg::OVERALL_RESET;
      st.fault_low <= probe_status_pkg::FAULT_RESET;
      st.fault_high <= probe_status_pkg::FAULT_RESET;
      st.meas <= {probe_status_pkg::MEAS_COUNT{probe_status_pkg::MEAS_RESET}};
      st.life <= probe_status_pkg::LIFE_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign resp_valid = st.resp_valid;
  assign resp_data = st.resp_data;
  assign resp_exception = st.resp_exception;
  assign resp_exc_code = st.resp_exc_code;
  assign obj_valid = st.obj_valid;
  assign obj_char = st.obj_char;
  assign obj_exception = st.obj_exception;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_critical_weight: assert property (fault_low_in[0] |=> st.overall[0])
    else $error("critical fault not reflected in overall condition");
  a_sum_of_weights: assert property (
    (fault_low_in[3] && fault_high_in[16] && !cal_mode &&
    !(|(fault_high_in & probe_status_pkg::HIGH_INFO_MASK)))
    |=> st.overall[4:1] == 4'b0011)
    else $error("error plus warning did not read as six");
  a_meas_failure: assert property (meas_flags[0][3] |=> st.meas[0][7])
    else $error("sensor failure weight missing");
  a_low_voltage: assert property (
    fault_low_in[4] |=> st.fault_low[4] && st.overall[1])
    else $error("internal low voltage not flagged as error");
  a_purge_notice: assert property (fault_high_in[13] |=> st.overall[3])
    else $error("purge not flagged as notification");
  a_life_lsw: assert property (
    (req_valid && !req_write && req_addr == probe_status_pkg::ADDR_SENSOR_LIFE)
    |=> resp_valid && resp_data == $past(sensor_life_in[15:0], 2))
    else $error("sensor life low word wrong");
  a_test_signed: assert property (
    (req_valid && !req_write && req_addr == probe_status_pkg::ADDR_TEST_SIGNED)
    |=> resp_data == 16'hcfc7 && !resp_exception)
    else $error("signed test constant wrong");
  a_float_order: assert property (
    (req_valid && !req_write && req_addr == probe_status_pkg::ADDR_TEST_FLOAT)
    ##2 (req_valid && !req_write && req_addr == 16'h1f02)
    |=> resp_data == 16'hc2f6 && $past(resp_data, 2) == 16'he666)
    else $error("float word order wrong");
  a_write_refused: assert property (
    (req_valid && req_write) |=> resp_valid && resp_exception && resp_exc_code != 8'h00)
    else $error("write was not refused");
  a_meas_locked: assert property (
    (req_valid && req_write && req_addr == probe_status_pkg::ADDR_PEROXIDE_COND)
    |=> resp_exc_code == probe_status_pkg::EXC_READ_ONLY)
    else $error("measurement condition write not refused as read only");
  a_date_empty: assert property (
    (obj_req && obj_id == 8'h81 && !cal_date_valid) |=> obj_valid && obj_char == 8'h00)
    else $error("invalid calibration date not empty");

  c_combined: cover property (st.overall[2] && st.overall[1]);
  c_pair_read: cover property (resp_valid && !resp_exception ##1 resp_valid);
  c_write: cover property (resp_valid && resp_exception);
  c_object: cover property (obj_valid && obj_char != 8'h00);
  c_all_meas: cover property (st.meas[2] == 16'h01e2);

endmodule : probe_status_bank

`default_nettype wire

// *** bench/host_model.sv ***
// Purpose: Host side model issuing register and object requests.
// Assumes: One request at a time; each answer is registered on the edge that takes it.
// Notes: Released request lines show inverted values so stale data cannot pass.
`default_nettype none

module host_model (
  // Clock
  input wire logic core_clk,
  // Register port
  output logic req_valid,
  output logic req_write,
  output logic [15:0] req_addr,
  input wire logic resp_valid,
  input wire logic [15:0] resp_data,
  input wire logic resp_exception,
  input wire logic [7:0] resp_exc_code,
  // Object port
  output logic obj_req,
  output logic [7:0] obj_id,
  output logic [5:0] obj_char_index,
  input wire logic obj_valid,
  input wire logic [7:0] obj_char,
  input wire logic obj_exception
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 16'h0000;
    obj_req = 1'b0;
    obj_id = 8'h00;
    obj_char_index = 6'h00;
  end

  // ---------------------------------------------------------------
  // Request tasks
  // ---------------------------------------------------------------
  // Addresses go out zero-based, as on the line
  task automatic reg_op(input logic wr, input logic [15:0] a, output logic [24:0] r,
    output logic ok);
    ok = 1'b0;
    r = 25'h0;
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr <= a;
    @(posedge core_clk);
    req_valid <= 1'b0;
    req_write <= ~wr;
    req_addr <= ~a;
    // Answer stands only in the cycle after the taking edge; look just past that edge
    for (int i = 0; i < 3 && !ok; i++) begin
      #1;
      if (resp_valid === 1'b1) begin
        ok = 1'b1;
        r = {resp_exception, resp_exc_code, resp_data};
      end else begin
        @(posedge core_clk);
      end
    end
  endtask : reg_op

  task automatic obj_op(input logic [7:0] id, input logic [5:0] idx, output logic [8:0] r,
    output logic ok);
    ok = 1'b0;
    r = 9'h0;
    @(posedge core_clk);
    obj_req <= 1'b1;
    obj_id <= id;
    obj_char_index <= idx;
    @(posedge core_clk);
    obj_req <= 1'b0;
    obj_id <= ~id;
    obj_char_index <= ~idx;
    for (int i = 0; i < 3 && !ok; i++) begin
      #1;
      if (obj_valid === 1'b1) begin
        ok = 1'b1;
        r = {obj_exception, obj_char};
      end else begin
        @(posedge core_clk);
      end
    end
  endtask : obj_op

endmodule : host_model

`default_nettype wire

// *** bench/probe_status_register_bank_bench.sv ***
// Purpose: Self-checking bench of the probe status register bank.
// Assumes: Condition inputs driven on the rising edge; host model makes requests.
// Notes: Serial text is arbitrary; texts are constant, only their valid flags move.
`default_nettype none

module probe_status_register_bank_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, reset_n, req_valid, req_write, resp_valid, resp_exception;
  logic [15:0] req_addr, resp_data;
  logic [7:0] resp_exc_code, obj_id, obj_char;
  logic obj_req, obj_valid, obj_exception, cal_mode, cal_date_valid, cal_info_valid;
  logic [5:0] obj_char_index;
  logic [31:0] fault_low_in, fault_high_in, sensor_life_in;
  logic [probe_status_pkg::MEAS_COUNT-1:0][probe_status_pkg::MEAS_FLAGS-1:0] meas_flags;
  int errors, total_checks;

  probe_status_bank u_probe_status_bank (.core_clk(core_clk), .reset_n(reset_n),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .resp_valid(resp_valid), .resp_data(resp_data), .resp_exception(resp_exception),
    .resp_exc_code(resp_exc_code), .obj_req(obj_req), .obj_id(obj_id),
    .obj_char_index(obj_char_index), .obj_valid(obj_valid), .obj_char(obj_char),
    .obj_exception(obj_exception), .fault_low_in(fault_low_in),
    .fault_high_in(fault_high_in), .meas_flags(meas_flags), .cal_mode(cal_mode),
    .sensor_life_in(sensor_life_in), .version_text({"1.2.3", 88'h0}),
    .unit_serial_object({"SN000001", 64'h0}), .cal_date_object("2020-01-31"),
    .cal_date_valid(cal_date_valid), .cal_info_object({"CAL/LAB", 200'h0}),
    .cal_info_valid(cal_info_valid));

  host_model u_host_model (.core_clk(core_clk), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .resp_valid(resp_valid),
    .resp_data(resp_data), .resp_exception(resp_exception), .resp_exc_code(resp_exc_code),
    .obj_req(obj_req), .obj_id(obj_id), .obj_char_index(obj_char_index),
    .obj_valid(obj_valid), .obj_char(obj_char), .obj_exception(obj_exception));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic give_verdict;
    if (errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic op(input logic wr, input logic [15:0] a, input logic [24:0] exp);
    logic [24:0] r;
    logic ok;
    u_host_model.reg_op(wr, a, r, ok);
    if (ok !== 1'b1) begin
      errors++;
      give_verdict();
    end
    check(32'(r), 32'(exp));
  endtask : op

  task automatic rd(input logic [15:0] a, input logic [15:0] d);
    op(1'b0, a, {9'h000, d});
  endtask : rd

  task automatic ob(input logic [7:0] id, input logic [5:0] idx, input logic [8:0] exp);
    logic [8:0] r;
    logic ok;
    u_host_model.obj_op(id, idx, r, ok);
    if (ok !== 1'b1) begin
      errors++;
      give_verdict();
    end
    check(32'(r), 32'(exp));
  endtask : ob

  task automatic apply(input logic [31:0] lo, hi, input logic cal, input logic [15:0] e);
    @(posedge core_clk);
    fault_low_in <= lo;
    fault_high_in <= hi;
    cal_mode <= cal;
    repeat (3) @(posedge core_clk);
    rd(16'h0200, e);
    rd(16'h0201, lo[15:0]);
    rd(16'h0202, lo[31:16]);
    rd(16'h0203, hi[15:0]);
    rd(16'h0204, hi[31:16]);
  endtask : apply

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic test_values;
    logic [63:0] txt;
    txt = {"-123.45", 8'h00};
    rd(16'h1f00, 16'(-12345));
    rd(16'h1f01, 16'he666);
    rd(16'h1f02, 16'hc2f6);
    for (int i = 0; i < 4; i++) begin
      rd(16'h1f03 + 16'(i), txt[63-16*i -: 16]);
    end
  endtask : test_values

  task automatic fault_codes;
    logic [31:0] w;
    logic [15:0] e;
    for (int b = 0; b < 20; b++) begin
      w = 32'h1 << b;
      if ((w & 32'h000c_c47b) != 0) begin
        apply(w, 32'h0, 1'b0, (b < 2) ? 16'h1 : 16'h2);
      end
      if ((w & 32'h0001_f300) != 0) begin
        e = ((w & 32'h5300) != 0) ? 16'h2 : (b == 16) ? 16'h4 : 16'h8;
        apply(32'h0, w, 1'b0, e);
      end
    end
    apply(32'h8, 32'h0001_0000, 1'b0, 16'h6);
    apply(32'h0, 32'h0, 1'b1, 16'h10);
    apply(32'h000c_c47b, 32'h0001_f300, 1'b1, 16'h1f);
    apply(32'h0, 32'h0, 1'b0, 16'h0);
  endtask : fault_codes

  task automatic meas_words;
    @(posedge core_clk);
    meas_flags <= {5'h18, 5'h06, 5'h01};
    repeat (3) @(posedge core_clk);
    rd(16'h0210, 16'h0002);
    rd(16'h0215, 16'h0060);
    rd(16'h0217, 16'h0180);
    @(posedge core_clk);
    meas_flags <= {5'h1f, 5'h1f, 5'h1f};
    repeat (3) @(posedge core_clk);
    op(1'b1, 16'h0210, {1'b1, 8'h01, 16'h0});
    rd(16'h0210, 16'h01e2);
    rd(16'h0217, 16'h01e2);
  endtask : meas_words

  task automatic refusals;
    op(1'b1, 16'h0200, {1'b1, 8'h01, 16'h0});
    op(1'b1, 16'h1f01, {1'b1, 8'h01, 16'h0});
    op(1'b1, 16'h0300, {1'b1, 8'h02, 16'h0});
    op(1'b0, 16'h0205, {1'b1, 8'h02, 16'h0});
    op(1'b0, 16'h1f07, {1'b1, 8'h02, 16'h0});
  endtask : refusals

  task automatic life_value;
    @(posedge core_clk);
    sensor_life_in <= 32'h42c8_0000;
    repeat (3) @(posedge core_clk);
    rd(16'h0222, 16'h0000);
    rd(16'h0223, 16'h42c8);
    @(posedge core_clk);
    sensor_life_in <= 32'h0;
    repeat (3) @(posedge core_clk);
    rd(16'h0223, 16'h0000);
  endtask : life_value

  task automatic objects;
    ob(8'h02, 6'd0, 9'h031);
    ob(8'h02, 6'd4, 9'h033);
    ob(8'h02, 6'd5, 9'h000);
    ob(8'h81, 6'd0, 9'h032);
    ob(8'h81, 6'd9, 9'h031);
    ob(8'h82, 6'd0, 9'h043);
    ob(8'h80, 6'd0, 9'h053);
    ob(8'h00, 6'd0, 9'h100);
    @(posedge core_clk);
    cal_date_valid <= 1'b0;
    cal_info_valid <= 1'b0;
    repeat (3) @(posedge core_clk);
    ob(8'h81, 6'd0, 9'h000);
    ob(8'h82, 6'd0, 9'h000);
  endtask : objects

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  initial begin
    errors = 0;
    total_checks = 0;
    reset_n = 1'b0;
    fault_low_in = 32'h0;
    fault_high_in = 32'h0;
    meas_flags = 15'h0;
    cal_mode = 1'b0;
    sensor_life_in = 32'h0;
    cal_date_valid = 1'b1;
    cal_info_valid = 1'b1;
    repeat (3) @(posedge core_clk);
    check({31'h0, resp_valid | obj_valid}, 32'h0);
    reset_n <= 1'b1;
    test_values();
    fault_codes();
    meas_words();
    refusals();
    life_value();
    objects();
    give_verdict();
  end
endmodule : probe_status_register_bank_bench

`default_nettype wire
